// file: logic/pmc_defines.svh
/*
 * Register indices, field positions, reset values and widths for the
 * power mode controller. Assumes inclusion by bare name, once per unit.
 */
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PMC_IDX_PWR_CTRL 8'hE0
`define PMC_IDX_SLP_CFG 8'hE1
`define PMC_IDX_STATUS 8'hE2
`define PMC_IDX_ACT_OVR 8'hF5
`define PMC_IDX_CLK_MODE 8'hFD
`define PMC_IDX_IDLE_GATE 8'hFE

// ****************************************************************
// Field positions
// ****************************************************************
`define PMC_PWR_IDLE_BIT 0
`define PMC_PWR_STOP_BIT 1
`define PMC_MODE_LOW_POWER_MODE_ENABLE_BIT 2
`define PMC_CFG_SUSP_BIT 6
`define PMC_CFG_SLEEP_BIT 7
`define PMC_CFG_WAKE_LSB 0
`define PMC_ST_MODE_LSB 0
`define PMC_ST_WAKE_LSB 4
`define PMC_ST_RST_LSB 12

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define PMC_GROUPS 4
`define PMC_WAKE_SRCS 6
`define PMC_RST_SRCS 3
`define PMC_GATE_RST 4'hF
`define PMC_OVR_RST 4'h0
`define PMC_BYTE_RST 8'h00

// ****************************************************************
// Wake source positions
// ****************************************************************
`define PMC_WK_RTC 0
`define PMC_WK_PORT 1
`define PMC_WK_CMP0 2
`define PMC_WK_RSTPIN 3
`define PMC_WK_PCNT 4
`define PMC_WK_VBAT 5

`endif

// file: logic/pmc_pkg.sv
/*
 * Types shared by the power mode controller files.
 * Assumes the defines header sits beside it.
 */
`include "pmc_defines.svh"

package pmc_pkg;

    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [2:0] {
        PMC_NORMAL,
        PMC_IDLE,
        PMC_STOP,
        PMC_LP_IDLE,
        PMC_SUSPEND,
        PMC_SLEEP
    } pmc_state_t;

    // ****************************************************************
    // Clock and supply gate bundle
    // ****************************************************************
    typedef struct packed {
        logic core_clk;
        logic core_run;
        logic sys_clk;
        logic prec_osc;
        logic int_osc;
        logic core_supply;
        logic rtc_osc;
        logic [`PMC_GROUPS-1:0] periph;
    } pmc_gate_t;

    // ****************************************************************
    // Core restart events
    // ****************************************************************
    typedef struct packed {
        logic resume_next;
        logic reset_to_zero;
    } pmc_core_evt_t;

endpackage

// file: logic/pmc_top.sv
/*
 * Power mode controller: APB register file, mode sequencer, clock gating.
 * Assumes an APB master on the system clock and a core that pulses
 * i_instr_done as each instruction retires.
 */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_top #(
    parameter int APB_AW = 12,
    parameter int NG = `PMC_GROUPS,
    parameter int NW = `PMC_WAKE_SRCS
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic i_wdt_enable,
    input wire logic i_wdt_expire,
    input wire logic i_mcd_enable,
    input wire logic i_mcd_timeout,
    input wire logic i_ext_reset,
    input wire logic [NW-1:0] i_wake_src,
    output pmc_pkg::pmc_gate_t o_gate,
    output pmc_pkg::pmc_core_evt_t o_core_evt,
    output logic o_wdt_run,
    output pmc_pkg::pmc_state_t o_state
);
    import pmc_pkg::*;

    // ****************************************************************
    // Decode helper
    // ****************************************************************
    function automatic logic addr_is(input logic [APB_AW-1:0] a, input logic [7:0] idx);
        addr_is = (a == APB_AW'({idx, 2'b00}));
    endfunction

    pmc_state_t state_reg;
    pmc_state_t state_next;
    logic [1:0] pwr_ctrl_reg;
    logic [7:0] slp_cfg_reg;
    logic [NG-1:0] act_ovr_reg;
    logic low_power_mode_enable_reg;
    logic [NG-1:0] idle_gate_reg;
    logic [`PMC_RST_SRCS-1:0] rst_cause_reg;
    logic [NW-1:0] wake_flags;
    logic [NW-1:0] wake_clr;
    logic wake_hit;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic [31:0] rdata;
    logic int_reset;
    logic irq_wake;
    logic [`PMC_RST_SRCS-1:0] rst_src;

    // ****************************************************************
    // APB slave: answer prepared in setup, zero wait states
    // ****************************************************************
    assign setup = i_psel && !i_penable;
    assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;

    always_comb begin
        mapped = 1'b1;
        rdata = 32'h0000_0000;
        if (addr_is(i_paddr, `PMC_IDX_PWR_CTRL)) begin
            rdata[1:0] = pwr_ctrl_reg;
        end else if (addr_is(i_paddr, `PMC_IDX_SLP_CFG)) begin
            rdata[7:0] = slp_cfg_reg;
        end else if (addr_is(i_paddr, `PMC_IDX_STATUS)) begin
            rdata[`PMC_ST_MODE_LSB +: 3] = state_reg;
            rdata[`PMC_ST_WAKE_LSB +: NW] = wake_flags;
            rdata[`PMC_ST_RST_LSB +: `PMC_RST_SRCS] = rst_cause_reg;
        end else if (addr_is(i_paddr, `PMC_IDX_ACT_OVR)) begin
            rdata[NG-1:0] = act_ovr_reg;
        end else if (addr_is(i_paddr, `PMC_IDX_CLK_MODE)) begin
            rdata[`PMC_MODE_LOW_POWER_MODE_ENABLE_BIT] = low_power_mode_enable_reg;
        end else if (addr_is(i_paddr, `PMC_IDX_IDLE_GATE)) begin
            rdata[NG-1:0] = idle_gate_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !mapped;
            o_prdata <= (setup && !i_pwrite) ? rdata : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Wake sources for suspend and sleep
    // ****************************************************************
    assign wake_clr = (wr_acc && addr_is(i_paddr, `PMC_IDX_STATUS)) ?
        i_pwdata[`PMC_ST_WAKE_LSB +: NW] : '0;

    pmc_wake_arb #(
        .N(NW)
    ) u_wake (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_armed(state_reg == PMC_SUSPEND || state_reg == PMC_SLEEP),
        .i_src(i_wake_src),
        .i_en(slp_cfg_reg[`PMC_CFG_WAKE_LSB +: NW]),
        .i_clr(wake_clr),
        .o_wake(wake_hit),
        .o_flags(wake_flags)
    );

    // ****************************************************************
    // Internal reset requests
    // ****************************************************************
    // Watchdog keeps counting through idle, so its expiry is honoured
    assign rst_src = {i_ext_reset,
                      i_mcd_enable && i_mcd_timeout,
                      i_wdt_enable && i_wdt_expire};
    assign int_reset = |rst_src;
    assign irq_wake = i_irq_pending &&
        (state_reg == PMC_IDLE || state_reg == PMC_LP_IDLE);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_cause_reg <= '0;
        end else if (int_reset) begin
            rst_cause_reg <= rst_src;
        end
    end

    // ****************************************************************
    // Software registers, reset back to defaults on internal reset
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_ctrl_reg <= 2'h0;
        end else if (int_reset) begin
            pwr_ctrl_reg <= 2'h0;
        end else if (irq_wake) begin
            pwr_ctrl_reg[`PMC_PWR_IDLE_BIT] <= 1'b0;
        end else if (state_reg != PMC_NORMAL) begin
            pwr_ctrl_reg <= pwr_ctrl_reg;
        end else if (wr_acc && addr_is(i_paddr, `PMC_IDX_PWR_CTRL)) begin
            pwr_ctrl_reg <= i_pwdata[1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slp_cfg_reg <= `PMC_BYTE_RST;
        end else if (int_reset) begin
            slp_cfg_reg <= `PMC_BYTE_RST;
        end else if (state_reg == PMC_SUSPEND || state_reg == PMC_SLEEP) begin
            if (wake_hit) begin
                slp_cfg_reg[`PMC_CFG_SUSP_BIT] <= 1'b0;
                slp_cfg_reg[`PMC_CFG_SLEEP_BIT] <= 1'b0;
            end
        end else if (wr_acc && addr_is(i_paddr, `PMC_IDX_SLP_CFG)) begin
            slp_cfg_reg <= i_pwdata[7:0];
        end
    end

    // Gating registers written in any order; software sequences them
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act_ovr_reg <= `PMC_OVR_RST;
            low_power_mode_enable_reg <= 1'b0;
            idle_gate_reg <= `PMC_GATE_RST;
        end else if (int_reset) begin
            act_ovr_reg <= `PMC_OVR_RST;
            low_power_mode_enable_reg <= 1'b0;
            idle_gate_reg <= `PMC_GATE_RST;
        end else if (wr_acc) begin
            if (addr_is(i_paddr, `PMC_IDX_ACT_OVR)) begin
                act_ovr_reg <= i_pwdata[NG-1:0];
            end else if (addr_is(i_paddr, `PMC_IDX_CLK_MODE)) begin
                low_power_mode_enable_reg <= i_pwdata[`PMC_MODE_LOW_POWER_MODE_ENABLE_BIT];
            end else if (addr_is(i_paddr, `PMC_IDX_IDLE_GATE)) begin
                idle_gate_reg <= i_pwdata[NG-1:0];
            end
        end
    end

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    // Select bits are only acted on at a retire pulse seen after the
    // write, so the writing instruction always completes first.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PMC_NORMAL: begin
                if (i_instr_done) begin
                    if (slp_cfg_reg[`PMC_CFG_SLEEP_BIT]) begin
                        state_next = PMC_SLEEP;
                    end else if (slp_cfg_reg[`PMC_CFG_SUSP_BIT]) begin
                        state_next = PMC_SUSPEND;
                    end else if (pwr_ctrl_reg[`PMC_PWR_STOP_BIT]) begin
                        state_next = PMC_STOP;
                    end else if (pwr_ctrl_reg[`PMC_PWR_IDLE_BIT]) begin
                        state_next = low_power_mode_enable_reg ? PMC_LP_IDLE : PMC_IDLE;
                    end
                end
            end
            PMC_IDLE, PMC_LP_IDLE: begin
                if (irq_wake) begin
                    state_next = PMC_NORMAL;
                end
            end
            PMC_STOP: begin
                state_next = PMC_STOP;
            end
            PMC_SUSPEND, PMC_SLEEP: begin
                if (wake_hit) begin
                    state_next = PMC_NORMAL;
                end
            end
            default: begin
                state_next = PMC_NORMAL;
            end
        endcase
        if (int_reset) begin
            state_next = PMC_NORMAL;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= PMC_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_state <= PMC_NORMAL;
        end else begin
            o_state <= state_next;
        end
    end

    // ****************************************************************
    // Core restart events
    // ****************************************************************
    // Resume continues after the halting instruction; reset restarts
    // fetch from address zero through the ordinary reset sequence.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_core_evt <= '0;
        end else begin
            o_core_evt.reset_to_zero <= int_reset;
            o_core_evt.resume_next <= !int_reset && (irq_wake ||
                ((state_reg == PMC_SUSPEND || state_reg == PMC_SLEEP) && wake_hit));
        end
    end

    // ****************************************************************
    // Clock and supply gating, from the next state to stay glitch free
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_gate <= '{core_clk: 1'b1, core_run: 1'b1, sys_clk: 1'b1, prec_osc: 1'b1,
                        int_osc: 1'b1, core_supply: 1'b1, rtc_osc: 1'b1,
                        periph: {NG{1'b1}}};
            o_wdt_run <= 1'b0;
        end else begin
            o_wdt_run <= i_wdt_enable;
            o_gate.rtc_osc <= 1'b1;
            o_gate.core_clk <= 1'b1;
            o_gate.core_run <= 1'b1;
            o_gate.sys_clk <= 1'b1;
            o_gate.prec_osc <= 1'b1;
            o_gate.int_osc <= 1'b1;
            o_gate.core_supply <= 1'b1;
            o_gate.periph <= {NG{1'b1}};
            case (state_next)
                PMC_NORMAL: begin
                    if (low_power_mode_enable_reg) begin
                        o_gate.periph <= act_ovr_reg | idle_gate_reg;
                        o_gate.core_clk <= 1'b1;
                    end
                end
                PMC_IDLE: begin
                    o_gate.core_run <= 1'b0;
                end
                PMC_LP_IDLE: begin
                    o_gate.core_run <= 1'b0;
                    o_gate.core_clk <= 1'b0;
                    o_gate.periph <= idle_gate_reg;
                end
                PMC_STOP: begin
                    o_gate.core_run <= 1'b0;
                    o_gate.core_clk <= 1'b0;
                    o_gate.prec_osc <= 1'b0;
                end
                PMC_SUSPEND: begin
                    o_gate.core_run <= 1'b0;
                    o_gate.core_clk <= 1'b0;
                    o_gate.sys_clk <= 1'b0;
                    o_gate.prec_osc <= 1'b0;
                    o_gate.int_osc <= 1'b0;
                    o_gate.periph <= {NG{1'b0}};
                end
                PMC_SLEEP: begin
                    o_gate.core_run <= 1'b0;
                    o_gate.core_clk <= 1'b0;
                    o_gate.sys_clk <= 1'b0;
                    o_gate.prec_osc <= 1'b0;
                    o_gate.int_osc <= 1'b0;
                    o_gate.core_supply <= 1'b0;
                    o_gate.periph <= {NG{1'b0}};
                end
                default: begin
                    o_gate.core_run <= 1'b1;
                end
            endcase
        end
    end

endmodule

// file: logic/pmc_wake_arb.sv
/*
 * Wake source arbiter for suspend and sleep: sticky flags and one wake pulse.
 * Assumes sources are synchronous to the system clock.
 */
`timescale 1ns/1ps
`include "pmc_defines.svh"

module pmc_wake_arb #(
    parameter int N = `PMC_WAKE_SRCS
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_armed,
    input wire logic [N-1:0] i_src,
    input wire logic [N-1:0] i_en,
    input wire logic [N-1:0] i_clr,
    output logic o_wake,
    output logic [N-1:0] o_flags
);
    import pmc_pkg::*;

    logic [N-1:0] hit;

    assign hit = i_armed ? (i_src & i_en) : '0;

    // ****************************************************************
    // Wake pulse
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= |hit;
        end
    end

    // ****************************************************************
    // Sticky flags, a new hit beats a clear
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_flags <= '0;
        end else begin
            o_flags <= (o_flags & ~i_clr) | hit;
        end
    end

endmodule

// file: testbench/pmc_core_model.sv
/* Core stand-in: retires instructions while clocked and running.
 * Assumes the controller's gate and restart outputs. */
`timescale 1ns/1ps
module pmc_core_model (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_slow,
    input wire pmc_pkg::pmc_gate_t i_gate,
    input wire pmc_pkg::pmc_core_evt_t i_evt,
    output logic o_instr_done,
    output int o_pc
);
    import pmc_pkg::*;
    // ********************
    // Retire and fetch
    // ********************
    logic [1:0] div_reg;
    logic run;
    // Slow mode retires every fourth cycle, like multi-cycle opcodes
    assign run = i_gate.core_run && i_gate.core_clk && i_gate.sys_clk && i_gate.core_supply;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_reg <= 2'h0;
            o_instr_done <= 1'b0;
            o_pc <= 0;
        end else begin
            div_reg <= div_reg + 2'h1;
            o_instr_done <= run && (!i_slow || div_reg == 2'h3);
            if (i_evt.reset_to_zero) begin
                o_pc <= 0;
            end else if (o_instr_done) begin
                o_pc <= o_pc + 1;
            end
        end
    end
endmodule

// file: testbench/pmc_top_assertions.sv
/* Port checker for pmc_top.
 * Assumes binding onto pmc_top; sees only its ports. */
`timescale 1ns/1ps
module pmc_top_assertions #(
    parameter int APB_AW = 12,
    parameter int NG = 4,
    parameter int NW = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic i_instr_done,
    input wire logic i_irq_pending,
    input wire logic i_wdt_enable,
    input wire logic i_wdt_expire,
    input wire logic i_mcd_enable,
    input wire logic i_mcd_timeout,
    input wire logic i_ext_reset,
    input wire logic [NW-1:0] i_wake_src,
    input wire pmc_pkg::pmc_gate_t o_gate,
    input wire pmc_pkg::pmc_core_evt_t o_core_evt,
    input wire logic o_wdt_run,
    input wire pmc_pkg::pmc_state_t o_state
);
    import pmc_pkg::*;
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    logic hit;
    assign hit = (i_wdt_enable && i_wdt_expire) || (i_mcd_enable && i_mcd_timeout) || i_ext_reset;
    sequence s_left_stop;
        o_state == PMC_STOP ##1 o_state == PMC_NORMAL;
    endsequence
    sequence s_left_low;
        (o_state == PMC_SUSPEND || o_state == PMC_SLEEP) ##1 o_state == PMC_NORMAL;
    endsequence
    a_state_legal: assert property (o_state <= PMC_SLEEP)
        else $error("state code");
    a_entry_on_done: assert property (o_state == PMC_NORMAL &&
        !i_instr_done |=> o_state == PMC_NORMAL) else $error("entry without done");
    a_idle_holds: assert property (o_state == PMC_IDLE && !i_irq_pending &&
        !hit |=> o_state == PMC_IDLE) else $error("idle left");
    a_idle_irq_wake: assert property ((o_state == PMC_IDLE ||
        o_state == PMC_LP_IDLE) && i_irq_pending && !hit |=>
        o_state == PMC_NORMAL && o_core_evt.resume_next) else $error("idle wake");
    a_int_reset: assert property (hit |=> o_state == PMC_NORMAL &&
        o_core_evt.reset_to_zero) else $error("internal reset");
    a_stop_holds: assert property (o_state == PMC_STOP && !hit |=>
        o_state == PMC_STOP) else $error("stop left");
    a_stop_exit_zero: assert property (s_left_stop |-> o_core_evt.reset_to_zero)
        else $error("stop exit");
    a_stop_gates: assert property (o_state == PMC_STOP |-> !o_gate.core_run &&
        !o_gate.core_clk && !o_gate.prec_osc) else $error("stop gates");
    a_lp_idle_clk: assert property (o_state == PMC_LP_IDLE |-> !o_gate.core_clk)
        else $error("lp idle clock");
    a_active_core_clk: assert property (o_state == PMC_NORMAL |-> o_gate.core_clk &&
        o_gate.core_run) else $error("active clock");
    a_susp_gates: assert property (o_state == PMC_SUSPEND |-> !o_gate.sys_clk &&
        !o_gate.int_osc && o_gate.periph == 4'h0) else $error("suspend gates");
    a_sleep_gates: assert property (o_state == PMC_SLEEP |-> !o_gate.core_supply &&
        o_gate.rtc_osc && !o_gate.sys_clk) else $error("sleep gates");
    a_low_wake_resume: assert property (s_left_low |->
        o_core_evt.resume_next || o_core_evt.reset_to_zero) else $error("wake resume");
    a_apb_ready: assert property (i_psel && !i_penable |=> o_pready)
        else $error("apb ready");
endmodule

bind pmc_top pmc_top_assertions #(.APB_AW(APB_AW), .NG(NG), .NW(NW)) pmc_top_assertions_i (.*);

// file: testbench/tb.sv
/* Self-checking bench for pmc_top with a core stand-in.
 * Assumes design, package and defines header compiled first. */
`timescale 1ns/1ps
`include "pmc_defines.svh"
module tb;
    import pmc_pkg::*;
    // ********************
    // Signals and tasks
    // ********************
    localparam logic [11:0] A_PWR = 12'(`PMC_IDX_PWR_CTRL * 4);
    localparam logic [11:0] A_CFG = 12'(`PMC_IDX_SLP_CFG * 4);
    localparam logic [11:0] A_ST = 12'(`PMC_IDX_STATUS * 4);
    localparam logic [11:0] A_OVR = 12'(`PMC_IDX_ACT_OVR * 4);
    localparam logic [11:0] A_MODE = 12'(`PMC_IDX_CLK_MODE * 4);
    localparam logic [11:0] A_GATE = 12'(`PMC_IDX_IDLE_GATE * 4);
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic irq = 1'b0, wdt_en = 1'b0, wdt_exp = 1'b0, mcd_en = 1'b0, mcd_to = 1'b0;
    logic ext_rst = 1'b0, slow = 1'b0, pready, pslverr, done, wdt_run, ev;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [5:0] wake = 6'h00;
    logic [3:0] ov, gt;
    pmc_gate_t gate;
    pmc_core_evt_t evt;
    pmc_state_t state, md;
    int pc, k, s, p0, nr, fail_count = 0, n_tests = 0, n_resume = 0, n_rzero = 0;

    always #2.5 clk = ~clk;
    pmc_top pmc_top_i (.i_clk_sys(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_instr_done(done), .i_irq_pending(irq),
        .i_wdt_enable(wdt_en), .i_wdt_expire(wdt_exp), .i_mcd_enable(mcd_en),
        .i_mcd_timeout(mcd_to), .i_ext_reset(ext_rst), .i_wake_src(wake), .o_gate(gate),
        .o_core_evt(evt), .o_wdt_run(wdt_run), .o_state(state));
    pmc_core_model pmc_core_model_i (.i_clk_sys(clk), .i_arst_n(rst_n), .i_slow(slow),
        .i_gate(gate), .i_evt(evt), .o_instr_done(done), .o_pc(pc));
    always @(posedge clk) begin
        if (evt.resume_next === 1'b1) n_resume++;
        if (evt.reset_to_zero === 1'b1) n_rzero++;
    end

    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // Caller sits just after a rising edge; request held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, 32'(pready));
        if (i == 20) wrap_up();
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
        input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(nm, e & m, rv & m);
    endtask
    task automatic wait_state(input pmc_state_t st);
        for (int i = 0; i < 200 && state !== st; i++) @(posedge clk);
        chk("state", 32'(st), 32'(state));
        if (state !== st) wrap_up();
    endtask

    // ********************
    // Scenarios
    // ********************
    initial begin
        void'($urandom(10563));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk("gate_rst", 32'h7FF, 32'(gate));
        rd("pwr", A_PWR, 32'h0, 32'hFFFFFFFF);
        rd("cfg", A_CFG, 32'h0, 32'hFFFFFFFF);
        rd("ovr", A_OVR, 32'h0, 32'hFFFFFFFF);
        rd("mode", A_MODE, 32'h0, 32'hFFFFFFFF);
        rd("igate", A_GATE, 32'hF, 32'hFFFFFFFF);
        rd("unmapped", 12'h3FC, 32'h0, 32'hFFFFFFFF);
        chk("slverr", 32'h1, 32'(ev));
        for (k = 0; k < 4; k++) begin
            ov = (k == 0) ? 4'h0 : 4'($urandom);
            gt = 4'($urandom);
            apb(1'b1, A_OVR, 32'(ov));
            apb(1'b1, A_GATE, 32'(gt));
            apb(1'b1, A_MODE, 32'h4);
            repeat (2) @(posedge clk);
            chk("act_periph", 32'(ov | gt), 32'(gate.periph));
            chk("act_core", 32'h1, 32'(gate.core_clk));
        end
        apb(1'b1, A_PWR, 32'h1);
        wait_state(PMC_LP_IDLE);
        repeat (2) @(posedge clk);
        chk("lpi_periph", 32'(gt), 32'(gate.periph));
        p0 = pc;
        nr = n_resume;
        irq <= 1'b1;
        wait_state(PMC_NORMAL);
        irq <= 1'b0;
        chk("pc_resume", 32'(p0), 32'(pc));
        @(posedge clk);
        chk("resume", 32'(nr + 1), 32'(n_resume));
        rd("pwr_clr", A_PWR, 32'h0, 32'h3);
        apb(1'b1, A_MODE, 32'h0);
        apb(1'b1, A_PWR, 32'h1);
        wait_state(PMC_IDLE);
        chk("idle_clk", 32'h1, 32'(gate.core_clk & ~gate.core_run));
        rd("ovr_kept", A_OVR, 32'(ov), 32'hF);
        wdt_en <= 1'b1;
        repeat (3) @(posedge clk);
        chk("wdt_run", 32'h1, 32'(wdt_run));
        nr = n_rzero;
        wdt_exp <= 1'b1;
        @(posedge clk);
        wdt_exp <= 1'b0;
        wdt_en <= 1'b0;
        wait_state(PMC_NORMAL);
        @(posedge clk);
        chk("rzero", 32'(nr + 1), 32'(n_rzero));
        rd("wdt_cause", A_ST, 32'h1000, 32'h7007);
        slow <= 1'b1;
        for (k = 0; k < 3; k++) begin
            apb(1'b1, A_PWR, 32'h2);
            wait_state(PMC_STOP);
            irq <= 1'b1;
            wdt_exp <= 1'b1;
            mcd_to <= 1'b1;
            repeat (3) @(posedge clk);
            chk("stop_hold", 32'(PMC_STOP), 32'(state));
            irq <= 1'b0;
            wdt_en <= (k == 0);
            wdt_exp <= (k == 0);
            mcd_en <= (k == 1);
            mcd_to <= (k == 1);
            ext_rst <= (k == 2);
            @(posedge clk);
            {wdt_en, wdt_exp, mcd_en, mcd_to, ext_rst} <= 5'h00;
            wait_state(PMC_NORMAL);
            rd("cause", A_ST, 32'h1000 << k, 32'h7007);
        end
        for (k = 0; k < 12; k++) begin
            s = k % 6;
            md = (k < 6) ? PMC_SUSPEND : PMC_SLEEP;
            apb(1'b1, A_CFG, (32'h1 << s) | ((k < 6) ? 32'h40 : 32'h80));
            wait_state(md);
            wake <= ~(6'h1 << s);
            repeat (3) @(posedge clk);
            chk("wake_off", 32'(md), 32'(state));
            nr = n_resume;
            wake <= 6'h1 << s;
            wait_state(PMC_NORMAL);
            wake <= 6'h00;
            @(posedge clk);
            chk("wake_resume", 32'(nr + 1), 32'(n_resume));
            rd("flag", A_ST, 32'h10 << s, 32'h10 << s);
            rd("sel_clr", A_CFG, 32'h1 << s, 32'hFF);
            apb(1'b1, A_ST, 32'h3F0);
            rd("flag_clr", A_ST, 32'h0, 32'h3F0);
        end
        wrap_up();
    end
endmodule
